/* File: hdl/sft_ctrl.sv */
// Register front end and level decode for the serial FIFOs
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module sft_ctrl (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  // Register port
  input  wire logic [sft_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [31:0]                       reg_rdata,
  // Channel setting
  input  wire logic                         fifo_enable_bit,
  input  wire sft_pkg::sft_dpx_t            duplex,
  // Shift logic events
  input  wire sft_pkg::sft_evt_t            rx_evt,
  input  wire sft_pkg::sft_evt_t            tx_evt,
  // FIFO control
  output logic                              rx_clear,
  output logic                              tx_clear,
  output logic [2:0]                        rx_depth,
  output logic [2:0]                        tx_depth,
  output logic                              rx_irq,
  output logic                              tx_irq
);
  sft_pkg::sft_cfg_t rx_fifo_config;
  sft_pkg::sft_cfg_t tx_fifo_config;
  logic [2:0] rx_fill;
  logic [2:0] tx_fill;
  logic       rx_hit;
  logic       tx_hit;

  wire full_dpx = (duplex == sft_pkg::SFT_DPX_FULL);
  wire wr_rx    = reg_wr && (reg_addr == sft_pkg::RX_CFG_OFS);
  wire wr_tx    = reg_wr && (reg_addr == sft_pkg::TX_CFG_OFS);
  wire clr_rx   = wr_rx && reg_wdata[sft_pkg::CLR_BIT];
  wire clr_tx   = wr_tx && reg_wdata[sft_pkg::CLR_BIT];

  // RX level: half 00=4, full 00=2 and 11=1
  function automatic logic [2:0] rx_lvl(input logic [1:0] f, input logic fd);
    if (f == 2'h0) rx_lvl = fd ? 3'h2 : 3'h4;
    else rx_lvl = (fd && f == 2'h3) ? 3'h1 : {1'b0, f};
  endfunction

  // TX level: full duplex only looks at the low bit
  function automatic logic [2:0] tx_lvl(input logic [1:0] f, input logic fd);
    tx_lvl = fd ? {2'h0, f[0]} : {1'b0, f};
  endfunction

  // Depth per duplex; a disabled FIFO holds nothing
  wire [2:0] next_rx_depth = !fifo_enable_bit ? 3'h0 :
                             full_dpx ? sft_pkg::DEPTH_FULL :
                             (duplex == sft_pkg::SFT_DPX_HALF_RX) ? sft_pkg::DEPTH_HALF : 3'h0;
  wire [2:0] next_tx_depth = !fifo_enable_bit ? 3'h0 :
                             full_dpx ? sft_pkg::DEPTH_FULL :
                             (duplex == sft_pkg::SFT_DPX_HALF_TX) ? sft_pkg::DEPTH_HALF : 3'h0;

  // Read mux; strobe and reserved bits always read zero
  wire [31:0] next_rdata =
    (reg_addr == sft_pkg::RX_CFG_OFS) ? {25'h0, rx_fifo_config.sel, 4'h0, rx_fifo_config.lvl} :
    (reg_addr == sft_pkg::TX_CFG_OFS) ? {25'h0, tx_fifo_config.sel, 4'h0, tx_fifo_config.lvl} :
    (reg_addr == sft_pkg::STAT_OFS)   ? {25'h0, tx_fill, 1'b0, rx_fill} : 32'h0;

  sft_level #(.IS_TX(1'b0)) u_rx (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (clr_rx),
    .depth    (next_rx_depth),
    .level    (rx_lvl(rx_fifo_config.lvl, full_dpx)),
    .cfg      (rx_fifo_config),
    .evt      (rx_evt),
    .fill     (rx_fill),
    .irq      (rx_hit)
  );

  sft_level #(.IS_TX(1'b1)) u_tx (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (clr_tx),
    .depth    (next_tx_depth),
    .level    (tx_lvl(tx_fifo_config.lvl, full_dpx)),
    .cfg      (tx_fifo_config),
    .evt      (tx_evt),
    .fill     (tx_fill),
    .irq      (tx_hit)
  );

  // Config storage, only bits 6 and 1:0 are kept
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_fifo_config <= sft_pkg::CFG_RESET;
      tx_fifo_config <= sft_pkg::CFG_RESET;
    end else begin
      if (wr_rx) rx_fifo_config <= {reg_wdata[sft_pkg::SEL_BIT], reg_wdata[1:0]};
      if (wr_tx) tx_fifo_config <= {reg_wdata[sft_pkg::SEL_BIT], reg_wdata[1:0]};
    end
  end

  // Registered outputs; clear is a one-cycle pulse to the FIFOs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
      rx_clear  <= 1'b0;
      tx_clear  <= 1'b0;
      rx_depth  <= 3'h0;
      tx_depth  <= 3'h0;
      rx_irq    <= 1'b0;
      tx_irq    <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0;
      rx_clear  <= clr_rx;
      tx_clear  <= clr_tx;
      rx_depth  <= next_rx_depth;
      tx_depth  <= next_tx_depth;
      rx_irq    <= rx_hit;
      tx_irq    <= tx_hit;
    end
  end
endmodule

/* File: hdl/sft_pkg.sv */
// Constants and types for the serial FIFO threshold controller
package sft_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] RX_CFG_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] TX_CFG_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] STAT_OFS   = 4'h8;
  localparam int CLR_BIT = 7;
  localparam int SEL_BIT = 6;
  localparam int LVL_LSB = 0;
  localparam logic [2:0] DEPTH_HALF = 3'h4;
  localparam logic [2:0] DEPTH_FULL = 3'h2;
  localparam logic [2:0] CFG_RESET  = 3'h0;

  // Duplex setting of the channel
  typedef enum logic [1:0] {SFT_DPX_OFF, SFT_DPX_HALF_RX, SFT_DPX_HALF_TX, SFT_DPX_FULL} sft_dpx_t;

  // One direction's configuration
  typedef struct packed {
    logic       sel;
    logic [1:0] lvl;
  } sft_cfg_t;

  // Shift-logic events for one direction
  typedef struct packed {
    logic push;
    logic pop;
  } sft_evt_t;
endpackage

/* File: hdl/sft_level.sv */
// Fill counter and threshold compare for one FIFO direction
`timescale 1ns/1ps
module sft_level #(
  parameter bit IS_TX = 1'b0
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             clear,
  input  wire logic [2:0]       depth,
  input  wire logic [2:0]       level,
  input  wire sft_pkg::sft_cfg_t cfg,
  input  wire sft_pkg::sft_evt_t evt,
  // Status
  output logic [2:0]            fill,
  output logic                  irq
);
  wire push_ok = evt.push && (fill < depth);
  wire pop_ok  = evt.pop && (fill != 3'h0);
  logic [2:0] next_fill;
  wire hit;
  wire extra;

  // Count next fill, an accepted push and pop together keep the fill
  assign next_fill = clear ? 3'h0 :
                     (push_ok && !pop_ok) ? fill + 3'h1 :
                     (pop_ok && !push_ok) ? fill - 3'h1 : fill;
  // Reaching the level means crossing into it this cycle
  assign hit = (next_fill == level) && (next_fill != fill) && !clear;
  // RX: read while above level; TX: data taken while below it
  assign extra = IS_TX ? (cfg.sel && pop_ok && (next_fill < level))
                       : (cfg.sel && pop_ok && (next_fill > level));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fill <= 3'h0;
      irq  <= 1'b0;
    end else begin
      fill <= next_fill;
      irq  <= hit || extra;
    end
  end
endmodule

/* File: tb/sft_ctrl_assertions.sv */
// Port checker for the serial FIFO controller
`timescale 1ns/1ps
module sft_chk (
  // Controller ports
  input wire logic                       core_clk, rst_n, reg_wr, reg_rd, fifo_enable_bit,
  input wire logic [sft_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0]                reg_wdata, reg_rdata,
  input wire sft_pkg::sft_dpx_t          duplex,
  input wire sft_pkg::sft_evt_t          rx_evt, tx_evt,
  input wire logic                       rx_clear, tx_clear, rx_irq, tx_irq,
  input wire logic [2:0]                 rx_depth
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Clear writes and byte activity per direction
  wire rx_cw = reg_wr && reg_addr == sft_pkg::RX_CFG_OFS && reg_wdata[7];
  wire tx_cw = reg_wr && reg_addr == sft_pkg::TX_CFG_OFS && reg_wdata[7];
  wire rx_act = rx_evt.push || rx_evt.pop;
  wire tx_act = tx_evt.push || tx_evt.pop;
  // Past values before reset release are masked in AST_DEPTH, settings may be held through it
  AST_RX_CLR: assert property (rx_cw |=> rx_clear) else $error("rx clear lost");
  AST_RX_SRC: assert property (rx_clear |-> $past(rx_cw)) else $error("stray rx clear");
  AST_TX_CLR: assert property (tx_cw |=> tx_clear) else $error("tx clear lost");
  AST_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 0) else $error("idle rdata");
  AST_RSV: assert property ($past(reg_rd) && $past(reg_addr) != sft_pkg::STAT_OFS
    |-> (reg_rdata & 32'hFFFFFFBC) == 0) else $error("reserved bits set");
  AST_DEPTH: assert property ($past(rst_n) && $past(fifo_enable_bit)
    && $past(duplex) == sft_pkg::SFT_DPX_FULL |-> rx_depth == 3'h2) else $error("depth");
  AST_RX_IRQ: assert property (rx_irq |-> $past(rx_act, 2)) else $error("rx irq");
  AST_TX_IRQ: assert property (tx_irq |-> $past(tx_act, 2)) else $error("tx irq");
  // Main scenarios reached
  cover property (rx_clear);
  cover property (rx_irq);
  cover property (tx_irq);
endmodule
bind sft_ctrl sft_chk chk (.*);

/* File: tb/sft_shift_model.sv */
// Shift logic model feeding byte events to the controller
`timescale 1ns/1ps
module sft_shift_model (
  // Clock in, events out: push brings a byte in, pop takes one out
  input wire logic          core_clk,
  output sft_pkg::sft_evt_t rx_evt,
  output sft_pkg::sft_evt_t tx_evt
);
  initial {rx_evt, tx_evt} = '0;
  // Only eight-bit frames are modelled, no nine-bit mode with FIFOs
  // Back-to-back pulses, the fastest pace the channel keeps
  task automatic burst(input bit tx, input bit push, input int n);
    repeat (n) @(posedge core_clk) if (tx) tx_evt <= {push, ~push}; else rx_evt <= {push, ~push};
    @(posedge core_clk) {rx_evt, tx_evt} <= '0;
  endtask
endmodule

/* File: tb/serial_fifo_threshold_ctrl_bench.sv */
// Bench for the serial FIFO controller
`timescale 1ns/1ps
module serial_fifo_threshold_ctrl_bench;
  logic              core_clk, rst_n, reg_wr, reg_rd, fifo_enable_bit;
  logic              rx_clear, tx_clear, rx_irq, tx_irq;
  logic [3:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata;
  logic [2:0]        rx_depth, tx_depth;
  sft_pkg::sft_dpx_t duplex;
  sft_pkg::sft_evt_t rx_evt, tx_evt;
  int                error_cnt, compares, cyc, rx_n, tx_n;
  sft_ctrl dut (.*);
  sft_shift_model shl (.*);
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  // Interrupt tallies; a hang ends far past the planned run
  always @(posedge core_clk) begin
    rx_n <= rx_n + rx_irq;
    tx_n <= tx_n + tx_irq;
    cyc <= cyc + 1;
    if (cyc == 2000) begin error_cnt++; close_out; end
  end
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin error_cnt++; $display("[FAIL] %0t got %h want %h", $time, got, exp); end
  endtask
  // One write, or one read whose data is judged in the cycle after
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge core_clk) {reg_wr, reg_rd} <= 2'h0;
    #1 if (!w) chk(reg_rdata, d);
  endtask
  // Clear under a fresh setting, stream bytes, tally interrupts
  task automatic run(input bit tx, input logic [7:0] cfg, input int np, nq, exp);
    bus(1, tx ? sft_pkg::TX_CFG_OFS : sft_pkg::RX_CFG_OFS, {24'h0, cfg | 8'h80});
    rx_n = 0;
    tx_n = 0;
    shl.burst(tx, 1, np);
    shl.burst(tx, 0, nq);
    repeat (3) @(posedge core_clk);
    #1 chk(tx ? tx_n : rx_n, exp);
  endtask
  task automatic t_regs;
    bus(0, sft_pkg::TX_CFG_OFS, 0);
    bus(1, sft_pkg::RX_CFG_OFS, 32'hFFFFFFFF);
    chk({rx_clear, tx_clear}, 2'h2);
    bus(0, sft_pkg::RX_CFG_OFS, 32'h43);
    bus(1, sft_pkg::TX_CFG_OFS, 32'hC2);
    chk({rx_clear, tx_clear}, 2'h1);
    bus(0, sft_pkg::TX_CFG_OFS, 32'h42);
    bus(1, 4'hC, 32'hFF);
    bus(0, 4'hC, 0);
  endtask
  task automatic t_depth;
    logic [5:0] want [4] = '{6'h00, 6'h20, 6'h04, 6'h12};
    for (int d = 0; d < 4; d++) begin
      @(posedge core_clk) fifo_enable_bit <= 1'h1;
      duplex <= sft_pkg::sft_dpx_t'(d);
      @(posedge core_clk) #1 chk({rx_depth, tx_depth}, want[d]);
    end
  endtask
  // Duplex is chosen before each clear so the depths are settled
  task automatic t_rx;
    @(posedge core_clk) duplex <= sft_pkg::SFT_DPX_HALF_RX;
    run(0, 8'h00, 3, 0, 0);
    run(0, 8'h00, 4, 0, 1);
    run(0, 8'h01, 3, 1, 1);
    run(0, 8'h41, 3, 1, 2);
    @(posedge core_clk) duplex <= sft_pkg::SFT_DPX_FULL;
    run(0, 8'h00, 2, 0, 1);
    run(0, 8'h03, 1, 0, 1);
    // Third byte is refused by the two-byte depth, fill stops at two
    run(0, 8'h00, 3, 0, 1);
    bus(0, sft_pkg::STAT_OFS, 32'h02);
  endtask
  task automatic t_tx;
    @(posedge core_clk) duplex <= sft_pkg::SFT_DPX_HALF_TX;
    run(1, 8'h00, 2, 2, 1);
    run(1, 8'h02, 1, 1, 0);
    run(1, 8'h42, 1, 1, 1);
    @(posedge core_clk) duplex <= sft_pkg::SFT_DPX_FULL;
    run(1, 8'h02, 1, 1, 1);
    run(1, 8'h03, 1, 0, 1);
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, fifo_enable_bit} = '0;
    duplex = sft_pkg::SFT_DPX_OFF;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    t_regs;
    t_depth;
    t_rx;
    t_tx;
    close_out;
  end
endmodule
